/* File: verilog/bld_defs.svh */
`ifndef BLD_DEFS_SVH
`define BLD_DEFS_SVH

// ****************************************************************
// Register byte offsets on the APB port.
// ****************************************************************
`define BLD_OFF_ROUTE 8'h00
`define BLD_OFF_SYNC 8'h04
`define BLD_OFF_DEPTH 8'h08
`define BLD_OFF_DIR 8'h0C
`define BLD_OFF_XCNT 8'h10
`define BLD_OFF_YCNT 8'h14
`define BLD_OFF_DMAJ 8'h18
`define BLD_OFF_DMIN 8'h1C
`define BLD_OFF_ERR 8'h20
`define BLD_OFF_SRC 8'h24
`define BLD_OFF_PAT 8'h28
`define BLD_OFF_MIX 8'h2C
`define BLD_OFF_ROP 8'h30
`define BLD_OFF_PITCH 8'h34
`define BLD_OFF_DST 8'h38
`define BLD_OFF_STATUS 8'h3C

// ****************************************************************
// Field positions.
// ****************************************************************
`define BLD_ROUTE_HOST_BIT 0
`define BLD_ROUTE_MIXEN_BIT 1
`define BLD_SYNC_EN_BIT 0
`define BLD_SYNC_ZW_BIT 1
`define BLD_DIR_XDEC_BIT 0
`define BLD_DIR_YDEC_BIT 1
`define BLD_DIR_XMAJ_BIT 2
`define BLD_DIR_ALG_BIT 4
`define BLD_DIR_LOAD_ERROR_TERM_SELECT_BIT 5
`define BLD_DIR_LINE_BIT 7
`define BLD_DEPTH_3BPP 2'h2

// ****************************************************************
// Reset values.
// ****************************************************************
`define BLD_SYNC_RST 2'h1
`define BLD_COUNT_RST 12'hFFF
`define BLD_ROP_RST 16'hF0CC
`define BLD_ROP_SRCCOPY 8'hCC

`endif

/* File: verilog/bld_pkg.sv */
package bld_pkg;

  typedef enum logic [1:0]
  {
    BLT_IDLE = 2'h0,
    BLT_FETCH = 2'h1,
    BLT_PROC = 2'h3,
    BLT_HOLD = 2'h2
  } bld_blit_state_type;

  typedef enum logic
  {
    LN_IDLE = 1'h0,
    LN_DRAW = 1'h1
  } bld_line_state_type;

endpackage : bld_pkg

/* File: verilog/bld_line_if.sv */
`timescale 1ns/1ns

interface bld_line_if;
  logic start;
  logic [7:0] dir;
  logic [11:0] xcnt;
  logic [11:0] ycnt;
  logic [11:0] dmaj;
  logic [11:0] dmin;
  logic [15:0] err;
  logic [1:0] bpp_m1;
  logic [31:0] dst;
  logic [31:0] pitch;
  logic busy;
  logic wr;
  logic [31:0] waddr;
  logic [1:0] lane;

  modport eng
  (
    input start, dir, xcnt, ycnt, dmaj, dmin, err, bpp_m1, dst, pitch,
    output busy, wr, waddr, lane
  );

  modport ctl
  (
    output start, dir, xcnt, ycnt, dmaj, dmin, err, bpp_m1, dst, pitch,
    input busy, wr, waddr, lane
  );
endinterface : bld_line_if

/* File: verilog/bld_line_engine.sv */
`timescale 1ns/1ns
`include "bld_defs.svh"

module bld_line_engine
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Control side.
  bld_line_if.eng ln
);

  bld_pkg::bld_line_state_type state_ff;
  logic [31:0] pix_ff;
  logic [1:0] bi_ff;
  logic [11:0] xc_ff;
  logic [11:0] yc_ff;
  logic signed [17:0] err_ff;
  logic signed [17:0] e2;
  logic signed [17:0] two_maj;
  logic minor;
  logic step_x;
  logic step_y;
  logic pix_done;
  logic last;
  logic [2:0] bpp;
  logic xdec;
  logic ydec;

  assign bpp = {1'b0, ln.bpp_m1} + 3'h1;
  assign xdec = ln.dir[`BLD_DIR_XDEC_BIT];
  assign ydec = ln.dir[`BLD_DIR_YDEC_BIT];
  assign two_maj = $signed({5'h00, ln.dmaj, 1'b0});
  assign e2 = err_ff + $signed({5'h00, ln.dmin, 1'b0});
  // A tie on the threshold steps the minor axis only under the default algorithm.
  assign minor = ln.dir[`BLD_DIR_ALG_BIT] ? (e2 > two_maj) : (e2 >= two_maj);
  assign step_x = ln.dir[`BLD_DIR_XMAJ_BIT] | minor;
  assign step_y = ~ln.dir[`BLD_DIR_XMAJ_BIT] | minor;
  assign pix_done = (state_ff == bld_pkg::LN_DRAW) && (bi_ff == ln.bpp_m1);
  assign last = (step_x && (xc_ff < {9'h000, bpp})) || (step_y && (yc_ff == 12'h000));

  assign ln.busy = (state_ff == bld_pkg::LN_DRAW);
  assign ln.wr = (state_ff == bld_pkg::LN_DRAW);
  // Bytes of a pixel are walked away from the anchor byte in the drawing direction.
  assign ln.waddr = xdec ? pix_ff - {30'h0, bi_ff} : pix_ff + {30'h0, bi_ff};
  assign ln.lane = bi_ff;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_ff <= bld_pkg::LN_IDLE;
    else if (state_ff == bld_pkg::LN_IDLE && ln.start)
      state_ff <= bld_pkg::LN_DRAW;
    else if (pix_done && last)
      state_ff <= bld_pkg::LN_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      bi_ff <= 2'h0;
    else if (ln.start || pix_done)
      bi_ff <= 2'h0;
    else if (state_ff == bld_pkg::LN_DRAW)
      bi_ff <= bi_ff + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pix_ff <= 32'h0000_0000;
      xc_ff <= 12'h000;
      yc_ff <= 12'h000;
      err_ff <= 18'sh00000;
    end
    else if (state_ff == bld_pkg::LN_IDLE && ln.start)
    begin
      pix_ff <= ln.dst;
      xc_ff <= ln.xcnt;
      yc_ff <= ln.ycnt;
      if (ln.dir[`BLD_DIR_LOAD_ERROR_TERM_SELECT_BIT])
        err_ff <= 18'(signed'(ln.err));
      else
        err_ff <= $signed({6'h00, ln.dmaj});
    end
    else if (pix_done && !last)
    begin
      pix_ff <= pix_ff
        + (step_x ? (xdec ? -{29'h0, bpp} : {29'h0, bpp}) : 32'h0000_0000)
        + (step_y ? (ydec ? -ln.pitch : ln.pitch) : 32'h0000_0000);
      xc_ff <= step_x ? xc_ff - {9'h000, bpp} : xc_ff;
      yc_ff <= step_y ? yc_ff - 12'h001 : yc_ff;
      err_ff <= minor ? e2 - two_maj : e2;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_ERR_INIT: assert property ((state_ff == bld_pkg::LN_IDLE && ln.start) |=>
      err_ff == ($past(ln.dir[`BLD_DIR_LOAD_ERROR_TERM_SELECT_BIT]) ? 18'(signed'($past(ln.err)))
      : $signed({6'h00, $past(ln.dmaj)})))
    else $error("Error term not initialised from the right source.");

  AST_END_ON_LIMIT: assert property ((pix_done && last) |=> !ln.busy)
    else $error("Line kept drawing after a count ran out.");

  AST_PIXEL_BYTES: assert property ((ln.busy && bi_ff != ln.bpp_m1) |=>
      (pix_ff == $past(pix_ff) && bi_ff == $past(bi_ff) + 2'h1))
    else $error("Line stepped before all bytes of the pixel were drawn.");

  AST_MAJOR_STEP: assert property ((pix_done && !last && ln.dir[`BLD_DIR_XMAJ_BIT]) |=>
      xc_ff == $past(xc_ff) - {9'h000, $past(bpp)})
    else $error("X-major line did not step along X.");

  COV_LINE_DONE: cover property (pix_done && last);
  COV_MINOR_STEP: cover property (pix_done && minor && !last);

endmodule : bld_line_engine

/* File: verilog/bld_top.sv */
`timescale 1ns/1ns
`include "bld_defs.svh"

// Overview of operation
// - With host routing, blit results go to the aperture, never to display memory; line draws still write display memory.
// - Unaligned source bytes are rotated into packed doublewords from lane zero.
// - With sync enabled and zero-wait off, aperture ready stays low until a result is held.
// - With zero-wait enabled, aperture reads complete with no wait state.
// - The line engine steps per pixel, drawing pixel-depth bytes each.
// - Direction: bit7 line, bit4 algorithm, bit2 X-major, bit1 Y-dec, bit0 X-dec.
// - A line ends when either count is exhausted.
// - Writing the destination starts; multi-byte pixels anchor by X direction.
// - Error term starts at major delta, or programmed value when selected.
// - Map address anchors the starting corner; no-X-wrap by 2/4/8 is unreliable.
// - At three bytes per pixel the four-byte wrap repeats three bytes.
// - Mix bit one applies foreground operation, zero the background one.
// - In blits with mix enabled, one mix bit controls exactly one byte; line draws ignore the mix bits.
// - Mix bits go LSB first when X increases, MSB first when decreasing.
module bld_top
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host result aperture.
  input wire logic ap_rd_req,
  input wire logic [31:0] ap_addr,
  output logic ap_ready,
  output logic [31:0] ap_rdata,
  // Display memory.
  output logic mem_rd,
  output logic [29:0] mem_raddr,
  input wire logic [31:0] mem_rdata,
  output logic mem_we,
  output logic [29:0] mem_waddr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_be,
  // Status.
  output logic busy
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  function automatic logic [7:0] rop_byte(input logic [7:0] rop, input logic [7:0] p,
                                          input logic [7:0] s, input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = rop[{p[i], s[i], d[i]}];
    return r;
  endfunction : rop_byte

  function automatic logic [1:0] lane3(input logic [2:0] v);
    return (v >= 3'h3) ? 2'(v - 3'h3) : v[1:0];
  endfunction : lane3

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `BLD_OFF_STATUS);
  endfunction : is_mapped

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [1:0] route_ff;
  logic [1:0] sync_ff;
  logic [1:0] depth_ff;
  logic [7:0] dir_ff;
  logic [11:0] xcnt_ff;
  logic [11:0] ycnt_ff;
  logic [11:0] dmaj_ff;
  logic [11:0] dmin_ff;
  logic [15:0] err_ff;
  logic [31:0] src_ff;
  logic [31:0] pat_ff;
  logic [31:0] mix_ff;
  logic [15:0] rop_ff;
  logic [31:0] pitch_ff;
  logic [31:0] dst_ff;
  logic [31:0] prdata_ff;
  logic wr_en;
  logic start;
  logic host_route;

  bld_pkg::bld_blit_state_type bstate_ff;
  logic first_ff;
  logic [31:0] prev_ff;
  logic [29:0] sptr_ff;
  logic [29:0] dptr_ff;
  logic [12:0] rem_ff;
  logic [4:0] mixi_ff;
  logic [1:0] patph_ff;
  logic [31:0] res_ff;
  logic resv_ff;
  logic [31:0] rot_word;
  logic [31:0] out_word;
  logic [3:0] last_be;
  logic ap_take;
  logic mem_we_ff;
  logic [29:0] mem_waddr_ff;
  logic [31:0] mem_wdata_ff;
  logic [3:0] mem_be_ff;
  logic [7:0] line_pat;

  bld_line_if ln ();

  assign host_route = route_ff[`BLD_ROUTE_HOST_BIT];
  assign wr_en = psel & penable & pwrite;
  assign busy = ln.busy | (bstate_ff != bld_pkg::BLT_IDLE);
  assign start = wr_en && (paddr == `BLD_OFF_DST) && !busy;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign prdata = prdata_ff;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      route_ff <= 2'h0;
      sync_ff <= `BLD_SYNC_RST;
      depth_ff <= 2'h0;
      dir_ff <= 8'h00;
      xcnt_ff <= `BLD_COUNT_RST;
      ycnt_ff <= `BLD_COUNT_RST;
      dmaj_ff <= 12'h000;
      dmin_ff <= 12'h000;
      err_ff <= 16'h0000;
      src_ff <= 32'h0000_0000;
      pat_ff <= 32'h0000_0000;
      mix_ff <= 32'hFFFF_FFFF;
      rop_ff <= `BLD_ROP_RST;
      pitch_ff <= 32'h0000_0000;
      dst_ff <= 32'h0000_0000;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `BLD_OFF_ROUTE: route_ff <= pwdata[1:0];
        `BLD_OFF_SYNC: sync_ff <= pwdata[1:0];
        `BLD_OFF_DEPTH: depth_ff <= pwdata[1:0];
        `BLD_OFF_DIR: dir_ff <= pwdata[7:0];
        `BLD_OFF_XCNT: xcnt_ff <= pwdata[11:0];
        `BLD_OFF_YCNT: ycnt_ff <= pwdata[11:0];
        `BLD_OFF_DMAJ: dmaj_ff <= pwdata[11:0];
        `BLD_OFF_DMIN: dmin_ff <= pwdata[11:0];
        `BLD_OFF_ERR: err_ff <= pwdata[15:0];
        `BLD_OFF_SRC: src_ff <= pwdata;
        `BLD_OFF_PAT: pat_ff <= pwdata;
        `BLD_OFF_MIX: mix_ff <= pwdata;
        `BLD_OFF_ROP: rop_ff <= pwdata[15:0];
        `BLD_OFF_PITCH: pitch_ff <= pwdata;
        `BLD_OFF_DST: dst_ff <= pwdata;
        default: dst_ff <= dst_ff;
      endcase
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      unique case (paddr)
        `BLD_OFF_ROUTE: prdata_ff <= {30'h0, route_ff};
        `BLD_OFF_SYNC: prdata_ff <= {30'h0, sync_ff};
        `BLD_OFF_DEPTH: prdata_ff <= {30'h0, depth_ff};
        `BLD_OFF_DIR: prdata_ff <= {24'h0, dir_ff};
        `BLD_OFF_XCNT: prdata_ff <= {20'h0, xcnt_ff};
        `BLD_OFF_YCNT: prdata_ff <= {20'h0, ycnt_ff};
        `BLD_OFF_DMAJ: prdata_ff <= {20'h0, dmaj_ff};
        `BLD_OFF_DMIN: prdata_ff <= {20'h0, dmin_ff};
        `BLD_OFF_ERR: prdata_ff <= {16'h0, err_ff};
        `BLD_OFF_SRC: prdata_ff <= src_ff;
        `BLD_OFF_PAT: prdata_ff <= pat_ff;
        `BLD_OFF_MIX: prdata_ff <= mix_ff;
        `BLD_OFF_ROP: prdata_ff <= {16'h0, rop_ff};
        `BLD_OFF_PITCH: prdata_ff <= pitch_ff;
        `BLD_OFF_DST: prdata_ff <= dst_ff;
        `BLD_OFF_STATUS: prdata_ff <= {28'h0, resv_ff, ln.busy, bstate_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Block transfer data path.
  // ****************************************************************
  // One extra source word is always prefetched, so aligned and unaligned
  // sources share a single path at the cost of one memory read.
  assign rot_word = 32'({mem_rdata, prev_ff} >> {src_ff[1:0], 3'h0});
  assign last_be = (rem_ff >= 13'h0004) ? 4'hF : 4'(4'h1 << rem_ff[1:0]) - 4'h1;

  always_comb
  begin
    logic [4:0] idx;
    logic mb;
    logic [1:0] pl;
    logic [7:0] pb;
    idx = 5'h00;
    mb = 1'b1;
    pl = 2'h0;
    pb = 8'h00;
    out_word = 32'h0000_0000;
    for (int k = 0; k < 4; k++)
    begin
      idx = mixi_ff + 5'(k);
      if (!route_ff[`BLD_ROUTE_MIXEN_BIT])
        mb = 1'b1;
      else if (dir_ff[`BLD_DIR_XDEC_BIT])
        mb = mix_ff[~idx];
      else
        mb = mix_ff[idx];
      if (depth_ff == `BLD_DEPTH_3BPP)
        pl = lane3({1'b0, patph_ff} + 3'(k));
      else
        pl = 2'(k);
      pb = pat_ff[{pl, 3'h0} +: 8];
      out_word[8*k +: 8] = mb ? rop_byte(rop_ff[7:0], pb, rot_word[8*k +: 8], 8'h00)
                              : rop_byte(rop_ff[15:8], pb, rot_word[8*k +: 8], 8'h00);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      bstate_ff <= bld_pkg::BLT_IDLE;
    else
    begin
      unique case (bstate_ff)
        bld_pkg::BLT_IDLE:
          if (start && !dir_ff[`BLD_DIR_LINE_BIT])
            bstate_ff <= bld_pkg::BLT_FETCH;
        bld_pkg::BLT_FETCH:
          bstate_ff <= bld_pkg::BLT_PROC;
        bld_pkg::BLT_PROC:
          if (first_ff)
            bstate_ff <= bld_pkg::BLT_FETCH;
          else if (host_route)
            bstate_ff <= bld_pkg::BLT_HOLD;
          else
            bstate_ff <= (rem_ff <= 13'h0004) ? bld_pkg::BLT_IDLE : bld_pkg::BLT_FETCH;
        bld_pkg::BLT_HOLD:
          if (!resv_ff)
            bstate_ff <= (rem_ff == 13'h0000) ? bld_pkg::BLT_IDLE : bld_pkg::BLT_FETCH;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      first_ff <= 1'b0;
      prev_ff <= 32'h0000_0000;
      sptr_ff <= 30'h0;
      dptr_ff <= 30'h0;
      rem_ff <= 13'h0000;
      mixi_ff <= 5'h00;
      patph_ff <= 2'h0;
    end
    else if (bstate_ff == bld_pkg::BLT_IDLE && start)
    begin
      first_ff <= 1'b1;
      sptr_ff <= src_ff[31:2];
      dptr_ff <= ln.dst[31:2];
      rem_ff <= {1'b0, xcnt_ff} + 13'h0001;
      mixi_ff <= 5'h00;
      patph_ff <= 2'h0;
    end
    else if (bstate_ff == bld_pkg::BLT_PROC)
    begin
      first_ff <= 1'b0;
      prev_ff <= mem_rdata;
      sptr_ff <= sptr_ff + 30'h1;
      if (!first_ff)
      begin
        dptr_ff <= dptr_ff + 30'h1;
        rem_ff <= (rem_ff > 13'h0004) ? rem_ff - 13'h0004 : 13'h0000;
        mixi_ff <= mixi_ff + 5'h04;
        patph_ff <= lane3({1'b0, patph_ff} + 3'h1);
      end
    end
  end

  // ****************************************************************
  // Host result aperture.
  // ****************************************************************
  // Zero-wait mode never stalls, so data may be stale if software reads early.
  assign ap_ready = ap_rd_req & (sync_ff[`BLD_SYNC_ZW_BIT]
                                 | ~sync_ff[`BLD_SYNC_EN_BIT] | resv_ff);
  assign ap_take = ap_rd_req & ap_ready & (ap_addr[1:0] == 2'h0);
  assign ap_rdata = res_ff;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      res_ff <= 32'h0000_0000;
      resv_ff <= 1'b0;
    end
    else if (bstate_ff == bld_pkg::BLT_PROC && !first_ff && host_route)
    begin
      res_ff <= out_word;
      resv_ff <= 1'b1;
    end
    else if (ap_take)
      resv_ff <= 1'b0;
  end

  // ****************************************************************
  // Display memory port and line engine.
  // ****************************************************************
  assign mem_rd = (bstate_ff == bld_pkg::BLT_FETCH);
  assign mem_raddr = sptr_ff;
  assign mem_we = mem_we_ff;
  assign mem_waddr = mem_waddr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_be = mem_be_ff;

  assign ln.start = start && dir_ff[`BLD_DIR_LINE_BIT];
  assign ln.dir = dir_ff;
  assign ln.xcnt = xcnt_ff;
  assign ln.ycnt = ycnt_ff;
  assign ln.dmaj = dmaj_ff;
  assign ln.dmin = dmin_ff;
  assign ln.err = err_ff;
  assign ln.bpp_m1 = depth_ff;
  // The address register only updates at the starting edge, so the start takes it off the bus.
  assign ln.dst = start ? pwdata : dst_ff;
  assign ln.pitch = pitch_ff;
  assign line_pat = pat_ff[{(depth_ff == `BLD_DEPTH_3BPP) ? ln.lane : ln.waddr[1:0], 3'h0} +: 8];

  bld_line_engine u_line
  (
    .clk(clk),
    .resetn(resetn),
    .ln(ln.eng)
  );

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      mem_we_ff <= 1'b0;
      mem_waddr_ff <= 30'h0;
      mem_wdata_ff <= 32'h0000_0000;
      mem_be_ff <= 4'h0;
    end
    else if (ln.wr)
    begin
      mem_we_ff <= 1'b1;
      mem_waddr_ff <= ln.waddr[31:2];
      mem_wdata_ff <= {4{rop_byte(rop_ff[7:0], line_pat, line_pat, 8'h00)}};
      mem_be_ff <= 4'(4'h1 << ln.waddr[1:0]);
    end
    else
    begin
      mem_we_ff <= (bstate_ff == bld_pkg::BLT_PROC) && !first_ff && !host_route;
      mem_waddr_ff <= dptr_ff;
      mem_wdata_ff <= out_word;
      mem_be_ff <= last_be;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_HOST_NO_MEMWR: assert property ((host_route && bstate_ff != bld_pkg::BLT_IDLE
      && !ln.busy) |=> !mem_we || !$past(host_route))
    else $error("Host-routed result was written to display memory.");

  AST_RESULT_HELD: assert property ((resv_ff && !ap_take) |=> resv_ff)
    else $error("Held result vanished before the host took it.");

  AST_LOW_ADDR_ONLY: assert property ((resv_ff && ap_rd_req && ap_ready
      && ap_addr[1:0] != 2'h0) |=> resv_ff)
    else $error("Misaligned aperture read consumed a result.");

  AST_ROTATE: assert property ((bstate_ff == bld_pkg::BLT_PROC && !first_ff && host_route
      && rop_ff[7:0] == `BLD_ROP_SRCCOPY && (rop_ff[15:8] == `BLD_ROP_SRCCOPY
      || !route_ff[`BLD_ROUTE_MIXEN_BIT] || mix_ff == 32'hFFFF_FFFF))
      |=> res_ff == $past(rot_word))
    else $error("Source bytes not packed from lane zero.");

  AST_SYNC_STALL: assert property ((sync_ff == 2'h1 && !resv_ff) |-> !ap_ready)
    else $error("Aperture ready given without a result under sync.");

  AST_ZERO_WAIT: assert property ((ap_rd_req && sync_ff[`BLD_SYNC_ZW_BIT]) |-> ap_ready)
    else $error("Wait state inserted in zero-wait mode.");

  AST_LINE_START: assert property ((start && dir_ff[`BLD_DIR_LINE_BIT]) |=> ##1 mem_we)
    else $error("Destination write did not start the line.");

  AST_PAT_PHASE: assert property ((depth_ff == `BLD_DEPTH_3BPP) |-> patph_ff != 2'h3)
    else $error("Three-byte wrap phase out of range.");

  COV_HOST_READ: cover property (ap_take && sync_ff == 2'h1);
  COV_MEM_BLIT: cover property (bstate_ff == bld_pkg::BLT_PROC && !first_ff && !host_route);
  COV_LINE_RUN: cover property (ln.busy ##1 !ln.busy);

endmodule : bld_top

/* File: sim/bld_host_model.sv */
`timescale 1ns/1ns

// ****************************************************************
// Host reader on the result aperture.
// ****************************************************************
module bld_host_model
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Bench side.
  input wire logic [7:0] want,
  input wire logic [29:0] hi_addr,
  output logic [7:0] got,
  output logic [7:0] waits,
  output logic [31:0] word,
  // Aperture.
  input wire logic ap_ready,
  input wire logic [31:0] ap_rdata,
  output logic ap_rd_req,
  output logic [31:0] ap_addr
);
  logic [7:0] wc;
  // Released address lines toggle, so a stale address never looks like a request.
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      ap_rd_req <= 1'b0;
      ap_addr <= 32'h0;
      got <= 8'h0;
      wc <= 8'h0;
    end
    else if (ap_rd_req && ap_ready)
    begin
      ap_rd_req <= 1'b0;
      ap_addr <= ~ap_addr;
      word <= ap_rdata;
      waits <= wc;
      wc <= 8'h0;
      got <= got + 8'h1;
    end
    else if (ap_rd_req)
      wc <= wc + 8'h1;
    else if (got != want)
    begin
      ap_rd_req <= 1'b1;
      ap_addr <= {hi_addr, 2'h0};
    end
    else
      ap_addr <= ~ap_addr;
  end
endmodule : bld_host_model

/* File: sim/tb_blit_line_draw_engine.sv */
`timescale 1ns/1ns
`include "bld_defs.svh"

// ****************************************************************
// Bench for the blit and line engine.
// ****************************************************************
module tb_blit_line_draw_engine;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic ap_rd_req, ap_ready, mem_rd, mem_we, busy;
  logic [7:0] paddr, got, waits, want;
  logic [31:0] pwdata, prdata, rd, mem_rdata, ap_rdata, ap_addr, word, d, fa, fd, lp, mem_wdata;
  logic [29:0] mem_raddr, hi_addr, mem_waddr;
  logic [3:0] mem_be, fb;
  int errors, comparisons, seed, wcnt, n;

  bld_top i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ap_rd_req(ap_rd_req), .ap_addr(ap_addr), .ap_ready(ap_ready),
    .ap_rdata(ap_rdata), .mem_rd(mem_rd), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .mem_be(mem_be), .busy(busy));
  bld_host_model i_host (.clk(clk), .resetn(resetn), .want(want), .hi_addr(hi_addr),
    .got(got), .waits(waits), .word(word), .ap_ready(ap_ready), .ap_rdata(ap_rdata),
    .ap_rd_req(ap_rd_req), .ap_addr(ap_addr));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction : mb

  always @(posedge clk)
  begin
    if (mem_rd === 1'b1)
      mem_rdata <= {mb({mem_raddr, 2'h3}), mb({mem_raddr, 2'h2}),
        mb({mem_raddr, 2'h1}), mb({mem_raddr, 2'h0})};
    if (mem_we === 1'b1 && wcnt == 0)
    begin
      fa <= {mem_waddr, 2'h0};
      fb <= mem_be;
      fd <= mem_wdata;
    end
    if (mem_we === 1'b1)
      wcnt++;
  end

  function automatic logic [31:0] expw(input logic [31:0] s, m, p, input int k);
    logic [31:0] r;
    for (int b = 0; b < 4; b++)
      r[8*b +: 8] = m[4*k+b] ? mb(s + 4*k + b) : p[8*b +: 8];
    return r;
  endfunction : expw

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_got(input logic [7:0] g);
    n = 0;
    while (got !== g && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check({24'h0, got}, {24'h0, g});
  endtask : wait_got

  task wait_idle;
    n = 0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    check({31'h0, busy}, 32'h0);
    repeat (3) @(negedge clk);
  endtask : wait_idle

  task close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task blit(input logic [31:0] s, input logic [31:0] m);
    logic [31:0] p;
    p = $random(seed);
    apb(1'b1, `BLD_OFF_ROUTE, 32'h3);
    apb(1'b1, `BLD_OFF_SRC, s);
    apb(1'b1, `BLD_OFF_PAT, p);
    apb(1'b1, `BLD_OFF_MIX, m);
    apb(1'b1, `BLD_OFF_ROP, 32'h0000F0CC);
    apb(1'b1, `BLD_OFF_DEPTH, 32'h0);
    apb(1'b1, `BLD_OFF_DIR, 32'h0);
    apb(1'b1, `BLD_OFF_XCNT, 32'h7);
    wcnt = 0;
    hi_addr <= 30'($random(seed));
    want <= got + 8'h2;
    apb(1'b1, `BLD_OFF_DST, 32'h0);
    wait_got(want - 8'h1);
    check(word, expw(s, m, p, 0));
    check({31'h0, waits != 8'h0}, 32'h1);
    wait_got(want);
    check(word, expw(s, m, p, 1));
    wait_idle;
    check(wcnt, 32'h0);
    $display("blit test done");
  endtask : blit

  task line(input logic [1:0] dp, input logic [7:0] dir, input logic [11:0] xc, yc, dj, dn,
    input logic [15:0] e, input int pix);
    apb(1'b1, `BLD_OFF_ROUTE, 32'h0);
    apb(1'b1, `BLD_OFF_DEPTH, {30'h0, dp});
    apb(1'b1, `BLD_OFF_DIR, {24'h0, dir});
    apb(1'b1, `BLD_OFF_XCNT, {20'h0, xc});
    apb(1'b1, `BLD_OFF_YCNT, {20'h0, yc});
    apb(1'b1, `BLD_OFF_DMAJ, {20'h0, dj});
    apb(1'b1, `BLD_OFF_DMIN, {20'h0, dn});
    apb(1'b1, `BLD_OFF_ERR, {16'h0, e});
    lp = {2{16'($random(seed))}};
    apb(1'b1, `BLD_OFF_PAT, lp);
    d = $random(seed) & 32'h000FFF00;
    d[1:0] = dir[0] ? dp : 2'h0;
    wcnt = 0;
    apb(1'b1, `BLD_OFF_DST, d);
    wait_idle;
    check(wcnt, 32'(pix * (dp + 1)));
    check(fa, {d[31:2], 2'h0});
    check({28'h0, fb}, {28'h0, 4'(4'h1 << d[1:0])});
    check(fd, {4{lp[8*d[1:0] +: 8]}});
    $display("line test done");
  endtask : line

  initial
  begin
    seed = 32'h40B5;
    errors = 0;
    comparisons = 0;
    wcnt = 0;
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    hi_addr = 30'h0;
    want = 8'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `BLD_OFF_SYNC, 32'h0);
    check(rd, {30'h0, `BLD_SYNC_RST});
    apb(1'b0, `BLD_OFF_ROP, 32'h0);
    check(rd, {16'h0, `BLD_ROP_RST});
    apb(1'b0, `BLD_OFF_MIX, 32'h0);
    check(rd, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    $display("reset test done");
    blit(($random(seed) & 32'h000FFFFC) | 32'h3, 32'hFFFFFFFF);
    repeat (3) blit($random(seed) & 32'h000FFFFF, $random(seed));
    apb(1'b1, `BLD_OFF_ROUTE, 32'h0);
    d = $random(seed) & 32'h000FFFFC;
    apb(1'b1, `BLD_OFF_SRC, d ^ 32'h0010_0000);
    wcnt = 0;
    apb(1'b1, `BLD_OFF_DST, d);
    wait_idle;
    check(wcnt, 32'h2);
    check(fa, d);
    $display("memory blit test done");
    apb(1'b1, `BLD_OFF_SYNC, 32'h3);
    want <= got + 8'h1;
    wait_got(got + 8'h1);
    check({24'h0, waits}, 32'h0);
    $display("zero wait test done");
    apb(1'b1, `BLD_OFF_SYNC, 32'h1);
    line(2'h0, 8'h84, 12'h9, 12'hFFF, 12'hA, 12'h3, 16'h0, 10);
    line(2'h0, 8'h95, 12'h9, 12'hFFF, 12'hA, 12'h3, 16'h0, 10);
    line(2'h2, 8'h84, 12'h9, 12'hFFF, 12'h4, 12'h1, 16'h0, 4);
    line(2'h1, 8'h83, 12'hFFF, 12'h5, 12'h6, 12'h2, 16'h0, 6);
    line(2'h0, 8'h84, 12'h9, 12'h2, 12'h4, 12'h0, 16'h0, 10);
    line(2'h0, 8'hA4, 12'h9, 12'h2, 12'h4, 12'h0, 16'h4000, 3);
    close_out;
  end

  initial
  begin
    #(40 * 40000);
    errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    close_out;
  end
endmodule : tb_blit_line_draw_engine
